// ### verilog/cmic_map.svh
// Purpose: Constants for the CAN mode and init control block
// Assumes: 200 MHz system clock
// Notes:   Offsets of none; codes and counts only
`ifndef CMIC_MAP_SVH
`define CMIC_MAP_SVH
`define CMIC_MAILBOX_MODE_SELECT_NORMAL 1'h0
`define CMIC_MAILBOX_MODE_SELECT_FIFO   1'h1
`define CMIC_TXF_DEPTH      3'h4
`define CMIC_RXF_WARN_LVL   3'h3
`define CMIC_BRP_RESET      10'h000
`define CMIC_TIME_SEGMENT_ONE_RESET    5'h0F
`define CMIC_TIME_SEGMENT_TWO_RESET    4'h8
`define CMIC_SJW_RESET      2'h1
`endif

// ### verilog/cmic_pkg.sv
// Purpose: Types for the CAN mode and init control block
// Assumes: Constants in cmic_map.svh
// Notes:   None
package cmic_pkg;
  typedef enum logic [2:0] {
    CMIC_SLEEP   = 3'b000,
    CMIC_RESET   = 3'b001,
    CMIC_HALT    = 3'b010,
    CMIC_OPERATE = 3'b011,
    CMIC_INIT    = 3'b100
  } cmic_mode_t;

  typedef struct packed {
    logic [9:0] baud_prescaler_divisor;
    logic [4:0] time_segment_one;
    logic [3:0] time_segment_two;
    logic [1:0] resync_jump_width;
  } cmic_timing_t;

  typedef struct packed {
    logic mailbox_mode_select;
    logic overwrite_en;
    logic mbx_num_priority;
    logic mask_valid;
  } cmic_mbx_cfg_t;

  typedef struct packed {
    logic listen_only_test;
    logic external_loopback_test;
    logic internal_loopback_test;
  } cmic_test_t;

  typedef struct packed {
    logic tx_done;
    logic txf_done;
    logic rx_done;
    logic rxf_done;
    logic err;
  } cmic_evt_t;
endpackage : cmic_pkg

// ### verilog/cmic_ctrl.sv
// Purpose: Mode sequencing, test modes, config and events of three CAN channels
// Assumes: All inputs synchronous to clk_sys_i
// Notes:   Channel select is a port; events pass a two-entry buffer
//
// What this block does
// - Channel starts in sleep after reset
// - Software can command low-power sleep
// - Halt keeps bus attached, stops traffic
// - Init wakes and enters init directly, with no reset step
// - Init ends: clear mailboxes, clear errors, operate
// - Mailbox mode: 0 plain, 1 FIFO
// - Overwrite option, enabled by init
// - Identifier priority default, mailbox priority option
// - Init marks all masks invalid
// - Timing holds prescaler, segments, jump width
// - Listen-only never drives ack or errors
// - External loopback transmits and hears itself
// - Internal loopback avoids external bus
// - Normal port restore leaves test modes
// - Plain mailbox transmit-complete event
// - Transmit FIFO event per entry or empty
// - Plain mailbox receive-complete event
// - Receive FIFO event per entry or warning
// - Bus error raises error event
// - Transmit FIFO holds four, reports full
`include "cmic_map.svh"
`timescale 1ns/1ps
module cmic_ctrl (
  input  wire logic                  clk_sys_i,
  input  wire logic                  resetn_i,
  input  wire logic                  clk_en_i,
  input  wire logic                  module_stop_i,
  input  wire logic [1:0]            chan_sel_i,
  input  wire logic                  leave_sleep_request_i,
  input  wire logic                  enter_sleep_request_i,
  input  wire logic                  reset_mode_request_i,
  input  wire logic                  halt_mode_request_i,
  input  wire logic                  operation_mode_request_i,
  input  wire logic                  init_request_i,
  input  wire logic                  init_mailbox_mode_select_i,
  input  wire logic                  timing_wr_i,
  input  wire cmic_pkg::cmic_timing_t timing_i,
  input  wire logic                  mbx_prio_wr_i,
  input  wire logic                  mbx_num_priority_i,
  input  wire logic                  overwrite_wr_i,
  input  wire logic                  overwrite_en_i,
  input  wire logic                  listen_only_test_i,
  input  wire logic                  external_loopback_test_i,
  input  wire logic                  internal_loopback_test_i,
  input  wire logic                  normal_port_restore_i,
  input  wire logic                  txf_on_empty_i,
  input  wire logic                  rxf_on_warn_i,
  input  wire logic                  mbx_tx_done_i,
  input  wire logic                  txf_push_i,
  input  wire logic                  txf_sent_i,
  input  wire logic                  mbx_rx_done_i,
  input  wire logic                  rxf_entry_i,
  input  wire logic [2:0]            rxf_level_i,
  input  wire logic                  bus_error_i,
  input  wire logic                  evt_ready_i,
  output logic                       evt_valid_o,
  output cmic_pkg::cmic_evt_t        evt_o,
  output logic [1:0]                 evt_chan_o,
  output cmic_pkg::cmic_mode_t       mode_o,
  output cmic_pkg::cmic_timing_t     timing_o,
  output cmic_pkg::cmic_mbx_cfg_t    mbx_cfg_o,
  output cmic_pkg::cmic_test_t       test_o,
  output logic                       bus_attach_o,
  output logic                       comm_en_o,
  output logic                       ack_drive_en_o,
  output logic                       ext_tx_en_o,
  output logic                       self_rx_en_o,
  output logic                       mbx_clear_o,
  output logic                       err_clear_o,
  output logic                       txf_full_o,
  output logic                       cmd_refused_o
);
  localparam int NCH = 3;

  cmic_pkg::cmic_mode_t    mode_r   [NCH];
  cmic_pkg::cmic_mode_t    mode_nxt;
  cmic_pkg::cmic_timing_t  timing_r [NCH];
  cmic_pkg::cmic_mbx_cfg_t mcfg_r   [NCH];
  cmic_pkg::cmic_test_t    test_r   [NCH];
  logic [2:0]              txf_cnt_r [NCH];
  logic [2:0]              init_step_r;
  logic [1:0]              buf_cnt_r;
  cmic_pkg::cmic_evt_t     buf_r    [2];
  logic [1:0]              bch_r    [2];
  logic                    evt_valid_r;
  cmic_pkg::cmic_evt_t     evt_r;
  logic [1:0]              evt_chan_r;
  logic                    mbx_clear_r;
  logic                    err_clear_r;
  logic                    refused_r;

  function automatic logic chan_ok(input logic [1:0] c);
    chan_ok = (c < 2'(NCH));
  endfunction : chan_ok

  wire         ch_ok   = chan_ok(chan_sel_i);
  wire [1:0]   ch      = ch_ok ? chan_sel_i : 2'h0;
  wire         wr_ok   = clk_en_i && !module_stop_i && ch_ok;
  cmic_pkg::cmic_mode_t cur;
  assign cur = mode_r[ch];
  wire in_reset = (cur == cmic_pkg::CMIC_RESET);
  wire in_init  = (cur == cmic_pkg::CMIC_INIT);
  wire tim_ok   = wr_ok && timing_wr_i && (in_reset || in_init);
  wire txf_full = (txf_cnt_r[ch] == `CMIC_TXF_DEPTH);
  wire push_ok  = txf_push_i && !txf_full;
  wire txf_pop  = txf_sent_i && (txf_cnt_r[ch] != 3'h0);
  wire [2:0] txf_cnt_nxt = txf_cnt_r[ch] + {2'h0, push_ok} - {2'h0, txf_pop};

  // Event sources for the selected channel
  cmic_pkg::cmic_evt_t ev_new;
  wire is_fifo = mcfg_r[ch].mailbox_mode_select;
  assign ev_new.tx_done  = mbx_tx_done_i && !is_fifo;
  assign ev_new.txf_done = txf_pop && (!txf_on_empty_i ||
                           (txf_cnt_nxt == 3'h0)) && is_fifo;
  assign ev_new.rx_done  = mbx_rx_done_i && !is_fifo;
  assign ev_new.rxf_done = rxf_entry_i && is_fifo && (!rxf_on_warn_i ||
                           (rxf_level_i == `CMIC_RXF_WARN_LVL));
  assign ev_new.err      = bus_error_i;
  wire ev_any = |ev_new;
  wire comm_ok = (cur == cmic_pkg::CMIC_OPERATE);

  // Mode sequencing
  always_comb
  begin
    mode_nxt = cur;
    if (in_init)
    begin
      if (init_step_r == 3'h3)
        mode_nxt = cmic_pkg::CMIC_OPERATE;
    end
    else if (init_request_i)
      mode_nxt = cmic_pkg::CMIC_INIT;
    else if (enter_sleep_request_i)
      mode_nxt = cmic_pkg::CMIC_SLEEP;
    else if (leave_sleep_request_i && cur == cmic_pkg::CMIC_SLEEP)
      mode_nxt = cmic_pkg::CMIC_RESET;
    else if (cur != cmic_pkg::CMIC_SLEEP)
    begin
      if (reset_mode_request_i)
        mode_nxt = cmic_pkg::CMIC_RESET;
      else if (halt_mode_request_i)
        mode_nxt = cmic_pkg::CMIC_HALT;
      else if (operation_mode_request_i)
        mode_nxt = cmic_pkg::CMIC_OPERATE;
    end
  end

  wire any_req = leave_sleep_request_i || enter_sleep_request_i || reset_mode_request_i ||
                 halt_mode_request_i || operation_mode_request_i || init_request_i;
  wire refuse  = clk_en_i && any_req && (module_stop_i || !ch_ok ||
                 (!in_init && mode_nxt == cur && !init_request_i));

  // Per-channel state
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        mode_r[i]    <= cmic_pkg::CMIC_SLEEP;
        timing_r[i]  <= '{`CMIC_BRP_RESET, `CMIC_TIME_SEGMENT_ONE_RESET,
                          `CMIC_TIME_SEGMENT_TWO_RESET, `CMIC_SJW_RESET};
        mcfg_r[i]    <= '{`CMIC_MAILBOX_MODE_SELECT_NORMAL, 1'b0, 1'b0, 1'b1};
        test_r[i]    <= '0;
        txf_cnt_r[i] <= 3'h0;
      end
    end
    else if (wr_ok)
    begin
      mode_r[ch] <= mode_nxt;
      if (tim_ok)
        timing_r[ch] <= timing_i;
      if (init_request_i && !in_init)
        mcfg_r[ch] <= '{init_mailbox_mode_select_i, 1'b1, 1'b0, 1'b0};
      else if (in_reset || cur == cmic_pkg::CMIC_HALT)
      begin
        if (mbx_prio_wr_i)
          mcfg_r[ch].mbx_num_priority <= mbx_num_priority_i;
        if (overwrite_wr_i)
          mcfg_r[ch].overwrite_en <= overwrite_en_i;
      end
      if (normal_port_restore_i)
        test_r[ch] <= '0;
      else if (listen_only_test_i || external_loopback_test_i || internal_loopback_test_i)
        test_r[ch] <= '{listen_only_test_i, external_loopback_test_i,
                        internal_loopback_test_i};
      if (in_init)
        txf_cnt_r[ch] <= 3'h0;
      else
        txf_cnt_r[ch] <= txf_cnt_nxt;
    end
  end

  // Init step counter and one-cycle clears
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      init_step_r <= 3'h0;
      mbx_clear_r <= 1'b0;
      err_clear_r <= 1'b0;
      refused_r   <= 1'b0;
    end
    else if (clk_en_i)
    begin
      init_step_r <= (wr_ok && in_init) ? init_step_r + 3'h1 : 3'h0;
      mbx_clear_r <= wr_ok && in_init && (init_step_r == 3'h2);
      err_clear_r <= wr_ok && in_init && (init_step_r == 3'h3);
      refused_r   <= refuse;
    end
  end

  // Two-entry event buffer
  wire buf_in  = wr_ok && ev_any;
  wire buf_out = (buf_cnt_r != 2'h0) && (!evt_valid_r || evt_ready_i);
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      buf_cnt_r   <= 2'h0;
      buf_r[0]    <= '0;
      buf_r[1]    <= '0;
      bch_r[0]    <= 2'h0;
      bch_r[1]    <= 2'h0;
      evt_valid_r <= 1'b0;
      evt_r       <= '0;
      evt_chan_r  <= 2'h0;
    end
    else if (clk_en_i)
    begin
      if (buf_out)
      begin
        evt_r      <= buf_r[0];
        evt_chan_r <= bch_r[0];
        buf_r[0]   <= buf_r[1];
        bch_r[0]   <= bch_r[1];
      end
      if (buf_out)
        evt_valid_r <= 1'b1;
      else if (evt_ready_i)
        evt_valid_r <= 1'b0;
      if (buf_in && buf_cnt_r != 2'h2)
      begin
        if (buf_cnt_r == 2'h0 || (buf_cnt_r == 2'h1 && buf_out))
        begin
          buf_r[0] <= ev_new;
          bch_r[0] <= ch;
        end
        else
        begin
          buf_r[1] <= ev_new;
          bch_r[1] <= ch;
        end
      end
      buf_cnt_r <= buf_cnt_r + {1'b0, buf_in && buf_cnt_r != 2'h2} - {1'b0, buf_out};
    end
  end

  // Registered outputs
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      mode_o         <= cmic_pkg::CMIC_SLEEP;
      timing_o       <= '0;
      mbx_cfg_o      <= '0;
      test_o         <= '0;
      bus_attach_o   <= 1'b0;
      comm_en_o      <= 1'b0;
      ack_drive_en_o <= 1'b0;
      ext_tx_en_o    <= 1'b0;
      self_rx_en_o   <= 1'b0;
      txf_full_o     <= 1'b0;
    end
    else if (clk_en_i)
    begin
      mode_o         <= cur;
      timing_o       <= timing_r[ch];
      mbx_cfg_o      <= mcfg_r[ch];
      test_o         <= test_r[ch];
      bus_attach_o   <= (cur == cmic_pkg::CMIC_HALT || comm_ok) &&
                        !test_r[ch].internal_loopback_test;
      comm_en_o      <= comm_ok;
      ack_drive_en_o <= comm_ok && !test_r[ch].listen_only_test &&
                        !test_r[ch].internal_loopback_test;
      ext_tx_en_o    <= comm_ok && !test_r[ch].listen_only_test &&
                        !test_r[ch].internal_loopback_test;
      self_rx_en_o   <= comm_ok && (test_r[ch].external_loopback_test ||
                        test_r[ch].internal_loopback_test);
      txf_full_o     <= txf_full;
    end
  end

  assign evt_valid_o   = evt_valid_r;
  assign evt_o         = evt_r;
  assign evt_chan_o    = evt_chan_r;
  assign mbx_clear_o   = mbx_clear_r;
  assign err_clear_o   = err_clear_r;
  assign cmd_refused_o = refused_r;
endmodule : cmic_ctrl

// ### test/cmic_ctrl_properties.sv
// Purpose: Port checker for cmic_ctrl
// Assumes: One clock domain
// Notes:   Bound to every cmic_ctrl
`timescale 1ns/1ps
module cmic_ctrl_properties (
  input wire logic                    clk_sys_i,
  input wire logic                    resetn_i,
  input wire logic                    clk_en_i,
  input wire logic                    module_stop_i,
  input wire logic [1:0]              chan_sel_i,
  input wire logic                    reset_mode_request_i,
  input wire logic                    operation_mode_request_i,
  input wire logic                    init_request_i,
  input wire logic                    normal_port_restore_i,
  input wire logic                    txf_push_i,
  input wire logic                    bus_error_i,
  input wire logic                    evt_ready_i,
  input wire logic                    evt_valid_o,
  input wire cmic_pkg::cmic_evt_t     evt_o,
  input wire cmic_pkg::cmic_mode_t    mode_o,
  input wire cmic_pkg::cmic_mbx_cfg_t mbx_cfg_o,
  input wire cmic_pkg::cmic_test_t    test_o,
  input wire logic                    bus_attach_o,
  input wire logic                    comm_en_o,
  input wire logic                    ack_drive_en_o,
  input wire logic                    mbx_clear_o,
  input wire logic                    err_clear_o,
  input wire logic                    txf_full_o,
  input wire logic                    cmd_refused_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  logic ok;
  assign ok = clk_en_i && !module_stop_i && chan_sel_i != 2'h3;
  property p_sleep_up;
    $rose(resetn_i) |-> mode_o == cmic_pkg::CMIC_SLEEP ##1 mode_o == cmic_pkg::CMIC_SLEEP;
  endproperty
  a_sleep_up: assert property (p_sleep_up) else $error("Not in sleep after reset");
  property p_init;
    ok && init_request_i && !$past(init_request_i) && mode_o != cmic_pkg::CMIC_INIT
      |=> ##1 mode_o == cmic_pkg::CMIC_INIT ##2 mbx_clear_o ##1 err_clear_o
      ##1 mode_o == cmic_pkg::CMIC_OPERATE;
  endproperty
  a_init: assert property (p_init) else $error("Init sequence wrong");
  property p_cfg;
    mode_o == cmic_pkg::CMIC_OPERATE && $past(mode_o) == cmic_pkg::CMIC_INIT
      && $stable(chan_sel_i) |-> mbx_cfg_o.overwrite_en && !mbx_cfg_o.mbx_num_priority
      && !mbx_cfg_o.mask_valid;
  endproperty
  a_cfg: assert property (p_cfg) else $error("Init defaults wrong");
  property p_halt;
    mode_o == cmic_pkg::CMIC_HALT && !test_o.internal_loopback_test && $stable(chan_sel_i)
      |-> bus_attach_o && !comm_en_o;
  endproperty
  a_halt: assert property (p_halt) else $error("Halt not quiet");
  property p_listen;
    test_o.listen_only_test |-> !ack_drive_en_o;
  endproperty
  a_listen: assert property (p_listen) else $error("Ack driven in listen");
  property p_restore;
    ok && normal_port_restore_i |-> ##[1:2] test_o == 3'h0;
  endproperty
  a_restore: assert property (p_restore) else $error("Test mode kept");
  property p_refuse;
    clk_en_i && (module_stop_i || chan_sel_i == 2'h3)
      && (reset_mode_request_i || operation_mode_request_i) |=> cmd_refused_o;
  endproperty
  a_refuse: assert property (p_refuse) else $error("Bad command not refused");
  property p_err_evt;
    ok && bus_error_i && !evt_valid_o && evt_ready_i && mode_o == cmic_pkg::CMIC_OPERATE
      |-> ##[1:3] evt_valid_o && evt_o.err;
  endproperty
  a_err_evt: assert property (p_err_evt) else $error("No error event");
  property p_hold;
    evt_valid_o && !evt_ready_i |=> evt_valid_o && $stable(evt_o);
  endproperty
  a_hold: assert property (p_hold) else $error("Event lost in stall");
  property p_full;
    $rose(txf_full_o) |-> $past(txf_push_i) || $past(txf_push_i, 2);
  endproperty
  a_full: assert property (p_full) else $error("Full without push");
  c_init: cover property (mbx_clear_o);
  c_full: cover property ($rose(txf_full_o));
  c_stall: cover property (evt_valid_o && !evt_ready_i);
endmodule : cmic_ctrl_properties
bind cmic_ctrl cmic_ctrl_properties u_cmic_ctrl_properties (.*);

// ### test/cmic_evt_sink.sv
// Purpose: Event consumer on the far side
// Assumes: Ready sampled with valid at rising edge
// Notes:   Slow mode accepts one cycle in eight
`timescale 1ns/1ps
module cmic_evt_sink (
  input  wire logic          clk_sys_i,
  input  wire logic          resetn_i,
  input  wire logic          slow_i,
  input  wire logic          evt_valid_i,
  input  wire cmic_pkg::cmic_evt_t evt_i,
  output logic               evt_ready_o,
  output cmic_pkg::cmic_evt_t last_o,
  output logic [7:0]         n_got_o
);
  logic [2:0] ph_r;
  assign evt_ready_o = !slow_i || ph_r == 3'h7;
  always_ff @(posedge clk_sys_i or negedge resetn_i)
    if (!resetn_i)
    begin
      ph_r <= 3'h0;
      last_o <= '0;
      n_got_o <= 8'h00;
    end
    else
    begin
      ph_r <= ph_r + 3'h1;
      if (evt_valid_i && evt_ready_o)
      begin
        last_o <= evt_i;
        n_got_o <= n_got_o + 8'h01;
      end
    end
endmodule : cmic_evt_sink

// ### test/tb_top.sv
// Purpose: Self-checking bench for cmic_ctrl
// Assumes: Event sink as far side
// Notes:   Fixed seed random timing and events
`timescale 1ns/1ps
module tb_top;
  logic clk_sys_i = 1'b0, resetn_i = 1'b0, stop = 1'b0, slow = 1'b0, mbm = 1'b0;
  logic t_wr = 1'b0, p_wr = 1'b0, toe = 1'b0, row = 1'b0;
  logic ce = 1'b1, fifo = 1'b0, popd = 1'b0;
  logic [1:0] echan;
  logic [5:0] rq = '0, ev = '0;
  logic [3:0] tst = '0;
  logic [2:0] lvl = '0;
  logic [1:0] chan = '0;
  logic [7:0] n_got, n0;
  cmic_pkg::cmic_timing_t tim = '0, tmo, t_exp;
  cmic_pkg::cmic_evt_t evt, last;
  cmic_pkg::cmic_mode_t mode;
  cmic_pkg::cmic_mbx_cfg_t cfg;
  cmic_pkg::cmic_test_t tsto;
  logic rdy, vld, att, cen, ack, etx, srx, full;
  int num_errors = 0, n_checks = 0, cyc = 0, seed = 32'h0EFC, txq = 0, k;
  int tbl[3] = '{0, 3, 5};
  always #2.5 clk_sys_i = ~clk_sys_i;
  cmic_ctrl u_cmic_ctrl (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .clk_en_i(ce), .module_stop_i(stop),
    .chan_sel_i(chan), .leave_sleep_request_i(rq[0]), .enter_sleep_request_i(rq[1]),
    .reset_mode_request_i(rq[2]), .halt_mode_request_i(rq[3]),
    .operation_mode_request_i(rq[4]), .init_request_i(rq[5]), .init_mailbox_mode_select_i(mbm),
    .timing_wr_i(t_wr), .timing_i(tim), .mbx_prio_wr_i(p_wr), .mbx_num_priority_i(1'b1),
    .overwrite_wr_i(p_wr), .overwrite_en_i(1'b1), .listen_only_test_i(tst[0]),
    .external_loopback_test_i(tst[1]), .internal_loopback_test_i(tst[2]),
    .normal_port_restore_i(tst[3]), .txf_on_empty_i(toe), .rxf_on_warn_i(row),
    .mbx_tx_done_i(ev[0]), .txf_push_i(ev[1]), .txf_sent_i(ev[2]), .mbx_rx_done_i(ev[3]),
    .rxf_entry_i(ev[4]), .rxf_level_i(lvl), .bus_error_i(ev[5]), .evt_ready_i(rdy),
    .evt_valid_o(vld), .evt_o(evt), .evt_chan_o(echan), .mode_o(mode), .timing_o(tmo),
    .mbx_cfg_o(cfg), .test_o(tsto), .bus_attach_o(att), .comm_en_o(cen),
    .ack_drive_en_o(ack), .ext_tx_en_o(etx), .self_rx_en_o(srx), .mbx_clear_o(),
    .err_clear_o(), .txf_full_o(full), .cmd_refused_o());
  cmic_evt_sink u_cmic_evt_sink (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .slow_i(slow),
    .evt_valid_i(vld), .evt_i(evt), .evt_ready_o(rdy), .last_o(last), .n_got_o(n_got));
  task conclude();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task chk_m(input cmic_pkg::cmic_mode_t exp);
    chk(mode, exp);
  endtask : chk_m
  task settle(input int n);
    repeat (n) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask : settle
  task req(input int i, input int n);
    @(posedge clk_sys_i) rq[i] <= 1'b1;
    @(posedge clk_sys_i) rq <= '0;
    settle(n);
  endtask : req
  function automatic logic [4:0] ev_exp(input int i);
    case (i)
      0: return fifo ? 5'h00 : 5'h10;
      2: return (fifo && popd && !(toe && txq != 0)) ? 5'h08 : 5'h00;
      3: return fifo ? 5'h00 : 5'h04;
      4: return (fifo && !(row && lvl != 3'h3)) ? 5'h02 : 5'h00;
      5: return 5'h01;
      default: return 5'h00;
    endcase
  endfunction : ev_exp
  task ev_chk(input int i);
    n0 = n_got;
    @(posedge clk_sys_i) ev[i] <= 1'b1;
    @(posedge clk_sys_i) ev <= '0;
    popd = (i == 2) && (txq != 0);
    txq = txq + ((i == 1) && (txq < 4)) - popd;
    for (int j = 0; j < 15 && n_got == n0; j++) settle(1);
    chk(n_got - n0, ev_exp(i) != 0);
    if (ev_exp(i) != 0) chk(last, ev_exp(i));
    if (ev_exp(i) != 0) chk(echan, chan);
  endtask : ev_chk
  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      num_errors++;
      conclude();
    end
  end
  initial
  begin
    repeat (2) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    settle(0);
    chk_m(cmic_pkg::CMIC_SLEEP);
    req(3, 3);
    chk_m(cmic_pkg::CMIC_SLEEP);
    req(0, 3);
    chk(mode !== cmic_pkg::CMIC_SLEEP, 1);
    req(2, 3);
    chk_m(cmic_pkg::CMIC_RESET);
    t_exp = 21'($random(seed));
    @(posedge clk_sys_i) tim <= t_exp;
    t_wr <= 1'b1;
    @(posedge clk_sys_i) t_wr <= 1'b0;
    req(3, 3);
    chk(tmo, t_exp);
    chk_m(cmic_pkg::CMIC_HALT);
    chk({att, cen}, 2'b10);
    @(posedge clk_sys_i) tim <= ~t_exp;
    t_wr <= 1'b1;
    p_wr <= 1'b1;
    @(posedge clk_sys_i) t_wr <= 1'b0;
    p_wr <= 1'b0;
    settle(2);
    chk(tmo, t_exp);
    chk(cfg.mbx_num_priority, 1);
    chk(cfg.overwrite_en, 1);
    req(4, 3);
    chk_m(cmic_pkg::CMIC_OPERATE);
    req(1, 3);
    chk_m(cmic_pkg::CMIC_SLEEP);
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk_sys_i) chan <= i[1:0];
      mbm <= i[0];
      req(5, 7);
      chk_m(cmic_pkg::CMIC_OPERATE);
      chk(cfg, {i[0], 3'b100});
      $display("init done on channel %0d", i);
    end
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_sys_i) tst[i] <= 1'b1;
      @(posedge clk_sys_i) tst <= '0;
      settle(2);
      chk(tsto, (i == 3) ? 0 : (3'h4 >> i));
      if (i < 3) chk((i == 0) ? ack : {etx, srx}, (i == 0) ? 0 : (i == 1) ? 3 : 1);
    end
    $display("test modes done");
    for (int i = 0; i < 6; i++) ev_chk(i);
    @(posedge clk_sys_i) chan <= 2'h1;
    row <= 1'b1;
    lvl <= 3'h2;
    fifo = 1'b1;
    ev_chk(4);
    @(posedge clk_sys_i) lvl <= 3'h3;
    ev_chk(4);
    @(posedge clk_sys_i) toe <= 1'b1;
    for (int i = 0; i < 4; i++) ev_chk(i < 2 ? 1 : 2);
    for (int i = 0; i < 4; i++) ev_chk(1);
    chk(full, 1);
    ev_chk(2);
    chk(full, 0);
    @(posedge clk_sys_i) chan <= 2'h2;
    fifo = 1'b0;
    repeat (12)
    begin
      k = tbl[$unsigned($random(seed)) % 3];
      ev_chk(k);
    end
    $display("events done");
    n0 = n_got;
    @(posedge clk_sys_i) slow <= 1'b1;
    ev <= 6'h20;
    @(posedge clk_sys_i) ev <= 6'h08;
    @(posedge clk_sys_i) ev <= '0;
    settle(40);
    chk(n_got - n0, 2);
    @(posedge clk_sys_i) slow <= 1'b0;
    stop <= 1'b1;
    req(4, 1);
    req(1, 3);
    chk_m(cmic_pkg::CMIC_OPERATE);
    @(posedge clk_sys_i) stop <= 1'b0;
    chan <= 2'h3;
    req(1, 1);
    @(posedge clk_sys_i) chan <= 2'h2;
    settle(2);
    chk_m(cmic_pkg::CMIC_OPERATE);
    @(posedge clk_sys_i) ce <= 1'b0;
    req(1, 3);
    @(posedge clk_sys_i) ce <= 1'b1;
    settle(2);
    chk_m(cmic_pkg::CMIC_OPERATE);
    $display("refusals done");
    conclude();
  end
endmodule : tb_top
